// ==== dv/rtch_master_asserts.sv ====
// rtch_master_asserts: bus and handshake checks on the master ports
// assumes one clock domain; bound to every rtch_master below
`timescale 1ns/100ps
`default_nettype none
module rtch_master_asserts
    import rtch_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // command and data
    input wire logic cmd_valid_in,
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic timeout_out,
    input wire logic rd_valid_out,
    input wire logic wr_take_out,
    // bus pins
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe_out,
    input wire logic sda_out,
    input wire logic sda_oe_out
);
    logic [15:0] rd_gap;
    logic [15:0] stop_age;
    logic [15:0] to_age;
    logic sda_oe_q;
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // saturates so long idle spells cannot wrap into a false short gap
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            rd_gap <= 16'h0000;
        else if (rd_valid_out)
            rd_gap <= 16'h0000;
        else if (rd_gap != 16'hffff)
            rd_gap <= rd_gap + 16'h0001;
    end
    // cycles since the stop edge; zero means no stop yet in this access
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            sda_oe_q <= 1'h0;
            stop_age <= 16'h0000;
        end
        else
        begin
            sda_oe_q <= sda_oe_out;
            if (sda_oe_q && !sda_oe_out && scl_in && busy_out)
                stop_age <= 16'h0001;
            else if (!busy_out)
                stop_age <= 16'h0000;
            else if (stop_age != 16'h0000 && stop_age != 16'hffff)
                stop_age <= stop_age + 16'h0001;
        end
    end
    // counters stand in for delay ranges too long for the tools
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            to_age <= 16'h0000;
        else if (!busy_out || !timeout_out)
            to_age <= 16'h0000;
        else if (to_age != 16'hffff)
            to_age <= to_age + 16'h0001;
    end
    ////////////////////////////////////////////////////////////
    od_pins_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
        else $error("bus pin driven high");
    idle_free_a: assert property (!busy_out |-> !scl_oe_out && !sda_oe_out)
        else $error("bus held while idle");
    cmd_busy_a: assert property (ce_in && cmd_valid_in && !busy_out && !done_out |=> busy_out)
        else $error("command not taken");
    done_end_a: assert property (done_out |-> !busy_out && $past(busy_out))
        else $error("done without access");
    start_soon_a: assert property ($rose(busy_out) |-> ##[1:800] ($rose(sda_oe_out) && scl_in))
        else $error("no start after command");
    stop_gap_a: assert property ($fell(sda_oe_out) && scl_in && busy_out |-> !scl_oe_out [*8])
        else $error("bus not quiet after stop");
    gap_len_a: assert property (done_out |-> stop_age >= 16'h0bb8 && stop_age <= 16'h0e10)
        else $error("stop gap wrong");
    gap_bound_a: assert property (stop_age <= 16'h0e10)
        else $error("no done after stop gap");
    timeout_done_a: assert property (busy_out && timeout_out |-> to_age <= 16'h1068)
        else $error("timeout did not end access");
    read_space_a: assert property (rd_valid_out |-> rd_gap >= 16'h2327)
        else $error("read bytes too close");
    read_seen_c: cover property (rd_valid_out);
    write_seen_c: cover property (wr_take_out);
    timeout_seen_c: cover property ($rose(timeout_out));
endmodule // rtch_master_asserts
bind rtch_master rtch_master_asserts rtch_master_asserts_i (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in),
    .cmd_valid_in(cmd_valid_in), .busy_out(busy_out), .done_out(done_out), .timeout_out(timeout_out),
    .rd_valid_out(rd_valid_out), .wr_take_out(wr_take_out), .scl_in(scl_in), .scl_out(scl_out),
    .scl_oe_out(scl_oe_out), .sda_out(sda_out), .sda_oe_out(sda_oe_out));
`default_nettype wire

// ==== dv/rtch_master_test.sv ====
// rtch_master_test: write, streaming read and timed-out plain read
// assumes the chip model beside the master and pull-ups on both lines
`timescale 1ns/100ps
`default_nettype none
module rtch_master_test;
    import rtch_pkg::*;
    localparam int LIMIT = 30000;
    logic clk_in = 1'b0, reset_in = 1'b1, ce_in = 1'b1, cmd_valid_in = 1'b0;
    rtch_cmd_t cmd_in = '0;
    logic [7:0] wr_data_in = 8'h00, rd_data_out, wdata;
    logic busy_out, done_out, nack_out, timeout_out, wr_take_out, rd_valid_out;
    logic scl_out, scl_oe_out, sda_out, sda_oe_out, dev_pull;
    wire logic scl_w = ~scl_oe_out;
    wire logic sda_w = ~(sda_oe_out | dev_pull);
    logic [7:0] exp_q [$];
    logic [31:0] seed = 32'd97344;
    int miscompares = 0, total_checks = 0, cycles = 0, takes = 0;
    rtch_master #(.ACCESS_LIMIT(LIMIT)) rtch_master_i (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in),
        .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .busy_out(busy_out), .done_out(done_out),
        .nack_out(nack_out), .timeout_out(timeout_out), .wr_data_in(wr_data_in), .wr_take_out(wr_take_out),
        .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .scl_in(scl_w), .scl_out(scl_out),
        .scl_oe_out(scl_oe_out), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe_out));
    rtch_rtc_model rtch_rtc_model_i (.scl_in(scl_w), .sda_in(sda_w), .pull_out(dev_pull));
    ////////////////////////////////////////////////////////////
    initial forever #5 clk_in = ~clk_in;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // one access; no other bound is needed, the cycle ceiling cuts a hang
    task automatic run(input rtch_op_t op, input logic [3:0] ptr, input logic [3:0] fmt, input logic [4:0] len);
        @(negedge clk_in);
        cmd_in = '{op, ptr, fmt, len};
        cmd_valid_in = 1'b1;
        @(negedge clk_in);
        cmd_valid_in = 1'b0;
        do @(negedge clk_in); while (done_out !== 1'b1);
    endtask
    ////////////////////////////////////////////////////////////
    always @(negedge clk_in)
    begin
        if (wr_take_out === 1'b1)
            takes++;
        if (rd_valid_out === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("read count", 8'h01, 8'h00);
            else
                check("read data", rd_data_out, exp_q.pop_front());
        end
    end
    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 130000)
        begin
            miscompares++;
            finish_test();
        end
    end
    initial
    begin
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        reset_in = 1'b0;
        seed = xs(seed);
        wdata = seed[7:0];
        wr_data_in = wdata;
        run(OP_WRITE, 4'hf, 4'h0, 5'h01);
        check("stored byte", rtch_rtc_model_i.regs[15], wdata);
        check("write format", {4'h0, rtch_rtc_model_i.fmt}, 8'h00);
        check("pointer after stop", {4'h0, rtch_rtc_model_i.ptr}, 8'h0f);
        check("write flags", {5'h00, busy_out, nack_out, timeout_out}, 8'h00);
        check("bytes taken", 8'(takes), 8'h01);
        exp_q.push_back(wdata);
        run(OP_RD_FMT, 4'hf, 4'h5, 5'h01);
        check("stream format", {4'h0, rtch_rtc_model_i.fmt}, 8'h05);
        check("stream flags", {6'h00, nack_out, timeout_out}, 8'h00);
        exp_q.push_back(wdata);
        // the limit runs out inside the third read byte, which is dropped
        exp_q.push_back(8'h80);
        run(OP_RD_CUR, 4'h0, 4'h0, 5'h04);
        check("timeout flag", {7'h00, timeout_out}, 8'h01);
        check("reads left", 8'(exp_q.size()), 8'h00);
        finish_test();
    end
endmodule // rtch_master_test
`default_nettype wire

// ==== dv/rtch_rtc_model.sv ====
// rtch_rtc_model: behavioural clock chip on the two-wire bus
// assumes pull-ups outside; pull_out high means the chip pulls data low
`timescale 1ns/100ps
`default_nettype none
module rtch_rtc_model #(
    parameter logic [6:0] ADDR = 7'h32,
    parameter longint LIMIT_NS = 64'h1dcd6500
)
(
    // bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic pull_out
);
    logic [7:0] regs [16];
    logic [7:0] sh;
    logic [3:0] ptr;
    logic [3:0] fmt;
    logic act, rd, mack, held;
    int bitn, byten;
    time t0;
    initial
    begin
        pull_out = 1'b0;
        ptr = 4'hf;
        {act, rd, mack, held, sh, fmt} = '0;
        {bitn, byten, t0} = '0;
        foreach (regs[i]) regs[i] = 8'h80 | 8'(i);
    end
    ////////////////////////////////////////////////////////////
    always @(negedge sda_in) if (scl_in === 1'b1)
    begin
        if (!held) t0 = $time;
        held = 1'b1;
        {act, rd, bitn, byten, pull_out} = {1'b1, 1'b0, -32'sd1, 32'd0, 1'b0};
    end
    always @(posedge sda_in) if (scl_in === 1'b1)
    begin
        {held, act, pull_out, ptr} = {3'h0, 4'hf};
    end
    always @(posedge scl_in) if (act)
    begin
        if (bitn < 8 && !rd) sh = {sh[6:0], sda_in};
        if (bitn == 8 && rd) mack = sda_in;
    end
    // past the window the chip lets go, so writes see no ack and reads float high
    always @(negedge scl_in) if (act)
    begin
        bitn = bitn + 1;
        if (held && ($time - t0) > LIMIT_NS)
            {act, pull_out, ptr} = {2'h0, 4'hf};
        else if (bitn == 8)
        begin
            pull_out = 1'b0;
            if (!rd && byten == 0)
            begin
                if (sh[7:1] != ADDR) act = 1'b0;
                else {rd, mack, pull_out} = {sh[0], 2'b01};
            end
            else if (!rd && byten == 1)
            begin
                {ptr, fmt, mack, pull_out} = {sh, 2'b01};
                rd = (fmt == 4'h4 || fmt == 4'h5);
            end
            else if (!rd)
            begin
                regs[ptr] = sh;
                ptr = ptr + 4'h1;
                pull_out = 1'b1;
            end
        end
        else if (bitn == 9)
        begin
            {bitn, pull_out} = {32'd0, 1'b0};
            byten = byten + 1;
            if (rd && !mack)
            begin
                sh = regs[ptr];
                ptr = ptr + 4'h1;
                pull_out = ~sh[7];
            end
        end
        else if (rd)
            pull_out = ~sh[7 - bitn];
    end
endmodule // rtch_rtc_model
`default_nettype wire

// ==== rtl/rtch_master.sv ====
// rtch_master: two-wire bus master that reads and writes the clock chip
// assumes open-drain pins with pull-ups outside; commands come from logic on clk_in
`timescale 1ns/100ps
`default_nettype none
module rtch_master
    import rtch_pkg::*;
#(
    parameter int ACCESS_LIMIT = ACCESS_LIMIT_CYCLES
)
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // command
    input wire logic cmd_valid_in,
    input wire rtch_cmd_t cmd_in,
    output logic busy_out,
    output logic done_out,
    output logic nack_out,
    output logic timeout_out,
    // data
    input wire logic [7:0] wr_data_in,
    output logic wr_take_out,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    // bus pins
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_out,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out
);

////////////////////////////////////////////////////////////////////////////////

    function automatic logic [7:0] addr_byte(input logic rw);
        addr_byte = {SLAVE_ADDR, rw};
    endfunction

    function automatic logic is_byte(input rtch_state_t s);
        is_byte = (s == ST_ADDR) || (s == ST_PTR) || (s == ST_WDATA) || (s == ST_RADDR) || (s == ST_RDATA);
    endfunction

    rtch_state_t state;
    rtch_cmd_t cmd;
    logic [1:0] phase;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic [4:0] cnt;
    logic ack_low;
    logic [7:0] qcnt;
    logic [11:0] gap_cnt;
    logic [25:0] acc_cnt;
    logic acc_over;
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic tick;
    logic step;
    logic gap_done;
    logic rx;

////////////////////////////////////////////////////////////////////////////////

    // pins come from another clock domain
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            scl_s1 <= 1'h1;
            scl_s2 <= 1'h1;
            sda_s1 <= 1'h1;
            sda_s2 <= 1'h1;
        end
        else if (ce_in)
        begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
        end
    end

    // quarter-period divider that makes the serial clock
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            qcnt <= 8'h00;
        else if (ce_in)
        begin
            if (state == ST_IDLE || qcnt == 8'(QTR_CYCLES - 1))
                qcnt <= 8'h00;
            else
                qcnt <= qcnt + 8'h01;
        end
    end

    assign tick = ce_in && (qcnt == 8'(QTR_CYCLES - 1));
    // a slave holding the clock low holds off the phase 2 step, stretching the low phase
    assign step = tick && !(phase == 2'h2 && !scl_s2);
    assign rx = (state == ST_RDATA);
    assign gap_done = (gap_cnt == 12'(STOP_GAP_CYCLES - 1));

    // access timer runs from the first start, repeated starts included
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            acc_cnt <= 26'h0000000;
            acc_over <= 1'h0;
        end
        else if (ce_in)
        begin
            if (state == ST_IDLE || state == ST_GAP)
            begin
                acc_cnt <= 26'h0000000;
                acc_over <= 1'h0;
            end
            else if (acc_cnt == 26'(ACCESS_LIMIT - 1))
                acc_over <= 1'h1;
            else
                acc_cnt <= acc_cnt + 26'h0000001;
        end
    end

    // bus stays quiet after stop so the device can apply its held carry
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            gap_cnt <= 12'h000;
        else if (ce_in)
        begin
            if (state != ST_GAP)
                gap_cnt <= 12'h000;
            else if (!gap_done)
                gap_cnt <= gap_cnt + 12'h001;
        end
    end

    // the pins are open drain: only the enables ever move
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            scl_out <= 1'h0;
            sda_out <= 1'h0;
        end
        else if (ce_in)
        begin
            scl_out <= 1'h0;
            sda_out <= 1'h0;
        end
    end

////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state <= ST_IDLE;
            cmd <= '0;
            phase <= 2'h0;
            bitn <= 4'h0;
            shreg <= 8'h00;
            cnt <= 5'h00;
            ack_low <= 1'h0;
            scl_oe_out <= 1'h0;
            sda_oe_out <= 1'h0;
            busy_out <= 1'h0;
            done_out <= 1'h0;
            nack_out <= 1'h0;
            timeout_out <= 1'h0;
            wr_take_out <= 1'h0;
            rd_data_out <= 8'h00;
            rd_valid_out <= 1'h0;
        end
        else if (ce_in)
        begin
            done_out <= 1'h0;
            wr_take_out <= 1'h0;
            rd_valid_out <= 1'h0;
            unique case (state)
                ST_IDLE:
                begin
                    phase <= 2'h0;
                    if (cmd_valid_in)
                    begin
                        cmd <= cmd_in;
                        busy_out <= 1'h1;
                        nack_out <= 1'h0;
                        timeout_out <= 1'h0;
                        if (cmd_in.op != OP_WRITE && cmd_in.len == 5'h00)
                            cnt <= LEN_ONE;
                        else
                            cnt <= cmd_in.len;
                        state <= ST_START;
                    end
                end
                ST_START, ST_RSTART:
                begin
                    if (step)
                    begin
                        phase <= phase + 2'h1;
                        unique case (phase)
                            2'h0: sda_oe_out <= 1'h0;
                            2'h1: scl_oe_out <= 1'h0;
                            2'h2: sda_oe_out <= 1'h1;
                            2'h3:
                            begin
                                scl_oe_out <= 1'h1;
                                bitn <= 4'h0;
                                if (state == ST_RSTART)
                                begin
                                    state <= ST_RADDR;
                                    shreg <= addr_byte(RW_READ);
                                end
                                else
                                begin
                                    state <= ST_ADDR;
                                    shreg <= addr_byte(cmd.op == OP_RD_CUR ? RW_READ : RW_WRITE);
                                end
                            end
                        endcase
                    end
                end
                ST_ADDR, ST_PTR, ST_WDATA, ST_RADDR, ST_RDATA:
                begin
                    if (step)
                    begin
                        phase <= phase + 2'h1;
                        unique case (phase)
                            2'h0:
                            begin
                                // data moves only while the clock is low
                                if (bitn != ACK_SLOT)
                                    sda_oe_out <= !rx && !shreg[7];
                                else
                                    sda_oe_out <= rx && (cnt != LEN_ONE);
                            end
                            2'h1: scl_oe_out <= 1'h0;
                            2'h2:
                            begin
                                if (bitn != ACK_SLOT)
                                    shreg <= {shreg[6:0], rx ? sda_s2 : 1'h0};
                                else
                                    ack_low <= !sda_s2;
                            end
                            2'h3:
                            begin
                                scl_oe_out <= 1'h1;
                                if (bitn != ACK_SLOT)
                                    bitn <= bitn + 4'h1;
                                else
                                begin
                                    bitn <= 4'h0;
                                    // our ack is let go at the next q0, never on the edge that lowers the clock
                                    if (acc_over)
                                    begin
                                        timeout_out <= 1'h1;
                                        state <= ST_STOP;
                                    end
                                    else if (!rx && !ack_low)
                                    begin
                                        nack_out <= 1'h1;
                                        state <= ST_STOP;
                                    end
                                    else
                                    begin
                                        unique case (state)
                                            ST_ADDR:
                                            begin
                                                if (cmd.op == OP_RD_CUR)
                                                    state <= ST_RDATA;
                                                else
                                                begin
                                                    state <= ST_PTR;
                                                    if (cmd.op == OP_RD_FMT)
                                                        shreg <= {cmd.ptr, FMT_STREAM_TOP, cmd.fmt[0]};
                                                    else
                                                        shreg <= {cmd.ptr, FMT_WRITE};
                                                end
                                            end
                                            ST_PTR, ST_WDATA:
                                            begin
                                                if (cmd.op == OP_RD_REP)
                                                    state <= ST_RSTART;
                                                else if (cmd.op == OP_RD_FMT)
                                                    state <= ST_RDATA;
                                                else if (cnt == 5'h00)
                                                    state <= ST_STOP;
                                                else
                                                begin
                                                    state <= ST_WDATA;
                                                    shreg <= wr_data_in;
                                                    wr_take_out <= 1'h1;
                                                    cnt <= cnt - 5'h01;
                                                end
                                            end
                                            ST_RADDR: state <= ST_RDATA;
                                            default:
                                            begin
                                                rd_data_out <= shreg;
                                                rd_valid_out <= 1'h1;
                                                cnt <= cnt - 5'h01;
                                                if (cnt == LEN_ONE)
                                                    state <= ST_STOP;
                                            end
                                        endcase
                                    end
                                end
                            end
                        endcase
                    end
                end
                ST_STOP:
                begin
                    if (step)
                    begin
                        phase <= phase + 2'h1;
                        unique case (phase)
                            2'h0: sda_oe_out <= 1'h1;
                            2'h1: scl_oe_out <= 1'h0;
                            2'h2: sda_oe_out <= 1'h0;
                            2'h3: state <= ST_GAP;
                        endcase
                    end
                end
                ST_GAP:
                begin
                    if (gap_done)
                    begin
                        busy_out <= 1'h0;
                        done_out <= 1'h1;
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

endmodule // rtch_master
`default_nettype wire

// ==== rtl/rtch_pkg.sv ====
// rtch_pkg: constants and types for the two-wire clock-chip bus master
// assumes a 100 MHz system clock; the serial clock is made here by a divider
package rtch_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_PERIOD_NS = 10000;
    // a quarter of a serial clock period, least time so rounded up
    localparam int QTR_CYCLES = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STOP_GAP_NS = 31000;
    localparam int STOP_GAP_CYCLES = (STOP_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_LIMIT_MS = 500;
    // longest time so rounded down
    localparam int ACCESS_LIMIT_CYCLES = ACCESS_LIMIT_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [6:0] SLAVE_ADDR = 7'h32;
    localparam logic RW_READ = 1'h1;
    localparam logic RW_WRITE = 1'h0;
    localparam logic [3:0] FMT_WRITE = 4'h0;
    localparam logic [2:0] FMT_STREAM_TOP = 3'h2;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [4:0] LEN_ONE = 5'h01;

    typedef enum logic [1:0] {
        OP_WRITE = 2'b00,
        OP_RD_REP = 2'b01,
        OP_RD_FMT = 2'b10,
        OP_RD_CUR = 2'b11
    } rtch_op_t;

    typedef struct packed {
        rtch_op_t op;
        logic [3:0] ptr;
        logic [3:0] fmt;
        logic [4:0] len;
    } rtch_cmd_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_START = 4'b0001,
        ST_ADDR = 4'b0010,
        ST_PTR = 4'b0011,
        ST_WDATA = 4'b0100,
        ST_RSTART = 4'b0101,
        ST_RADDR = 4'b0110,
        ST_RDATA = 4'b0111,
        ST_STOP = 4'b1000,
        ST_GAP = 4'b1001
    } rtch_state_t;
endpackage
